// ### verilog/dpmb_pkg.sv
package dpmb_pkg;

  // one mail word spans the whole port width
  localparam int unsigned WORD_W = 36;

  // mailbox contents after reset
  localparam logic [35:0] MAIL_RESET = 36'h000000000;

  // flags are active low: high means the box is empty
  localparam logic FLAG_EMPTY = 1'b1;
  localparam logic FLAG_FULL  = 1'b0;

  // output enables are active low
  localparam logic OE_OFF = 1'b1;
  localparam logic OE_ON  = 1'b0;

  // pin synchroniser depth for the port clocks
  localparam int unsigned SYNC_DEPTH = 3;

  // kinds of qualified access seen on a port clock edge
  typedef enum logic [1:0] {
    dpmb_idle,
    dpmb_mail_wr,
    dpmb_mail_rd,
    dpmb_fifo_xfer
  } dpmb_access_t;

endpackage

// ### verilog/dpmb_mailbox.sv
module dpmb_mailbox (
  // system
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // port A pins
  input  wire logic        port_a_clock,
  input  wire logic        port_a_chip_select_n,
  input  wire logic        port_a_write_not_read,
  input  wire logic        port_a_enable,
  input  wire logic        mailbox_select_a,
  input  wire logic [35:0] port_a_data_in,
  output logic      [35:0] port_a_data_out,
  output logic             port_a_data_oe_n,
  // port B pins
  input  wire logic        port_b_clock,
  input  wire logic        port_b_chip_select_n,
  input  wire logic        port_b_write_not_read,
  input  wire logic        port_b_enable,
  input  wire logic        mailbox_select_b,
  input  wire logic [35:0] port_b_data_in,
  output logic      [35:0] port_b_data_out,
  output logic             port_b_data_oe_n,
  // mailbox status pins
  output logic             mail_a_to_b_flag_n,
  output logic             mail_b_to_a_flag_n,
  // FIFO storage path
  input  wire logic [35:0] fifo_out_data,
  output logic             fifo_write,
  output logic      [35:0] fifo_write_data,
  output logic             fifo_read
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // every port pin crosses from its own clock, so all take three stages;
  // a port clock level is only believed once stages two and three agree,
  // which filters a one-sample glitch at the cost of a cycle of latency
  logic [2:0]  a_clk_sync;
  logic [2:0]  b_clk_sync;
  logic        a_clk_level;
  logic        b_clk_level;
  logic [3:0]  a_ctl_s1;
  logic [3:0]  a_ctl_s2;
  logic [3:0]  a_ctl_s3;
  logic [3:0]  b_ctl_s1;
  logic [3:0]  b_ctl_s2;
  logic [3:0]  b_ctl_s3;
  logic [35:0] a_data_s1;
  logic [35:0] a_data_s2;
  logic [35:0] a_data_s3;
  logic [35:0] b_data_s1;
  logic [35:0] b_data_s2;
  logic [35:0] b_data_s3;
  logic [2:0]  next_a_clk_sync;
  logic [2:0]  next_b_clk_sync;
  logic        next_a_clk_level;
  logic        next_b_clk_level;
  logic [3:0]  next_a_ctl_s1;
  logic [3:0]  next_a_ctl_s2;
  logic [3:0]  next_a_ctl_s3;
  logic [3:0]  next_b_ctl_s1;
  logic [3:0]  next_b_ctl_s2;
  logic [3:0]  next_b_ctl_s3;
  logic [35:0] next_a_data_s1;
  logic [35:0] next_a_data_s2;
  logic [35:0] next_a_data_s3;
  logic [35:0] next_b_data_s1;
  logic [35:0] next_b_data_s2;
  logic [35:0] next_b_data_s3;

  always_comb
  begin
    next_a_clk_sync  = {a_clk_sync[1:0], port_a_clock};
    next_b_clk_sync  = {b_clk_sync[1:0], port_b_clock};
    next_a_clk_level = a_clk_level;
    next_b_clk_level = b_clk_level;
    if (a_clk_sync[1] == a_clk_sync[2])
      next_a_clk_level = a_clk_sync[2];
    if (b_clk_sync[1] == b_clk_sync[2])
      next_b_clk_level = b_clk_sync[2];
    next_a_ctl_s1    = {mailbox_select_a, port_a_enable, port_a_write_not_read, port_a_chip_select_n};
    next_a_ctl_s2    = a_ctl_s1;
    next_a_ctl_s3    = a_ctl_s2;
    next_b_ctl_s1    = {mailbox_select_b, port_b_enable, port_b_write_not_read, port_b_chip_select_n};
    next_b_ctl_s2    = b_ctl_s1;
    next_b_ctl_s3    = b_ctl_s2;
    next_a_data_s1   = port_a_data_in;
    next_a_data_s2   = a_data_s1;
    next_a_data_s3   = a_data_s2;
    next_b_data_s1   = port_b_data_in;
    next_b_data_s2   = b_data_s1;
    next_b_data_s3   = b_data_s2;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_clk_sync  <= 3'h0;
      b_clk_sync  <= 3'h0;
      a_clk_level <= 1'b0;
      b_clk_level <= 1'b0;
      a_ctl_s1    <= 4'h1;
      a_ctl_s2    <= 4'h1;
      a_ctl_s3    <= 4'h1;
      b_ctl_s1    <= 4'h1;
      b_ctl_s2    <= 4'h1;
      b_ctl_s3    <= 4'h1;
      a_data_s1   <= dpmb_pkg::MAIL_RESET;
      a_data_s2   <= dpmb_pkg::MAIL_RESET;
      a_data_s3   <= dpmb_pkg::MAIL_RESET;
      b_data_s1   <= dpmb_pkg::MAIL_RESET;
      b_data_s2   <= dpmb_pkg::MAIL_RESET;
      b_data_s3   <= dpmb_pkg::MAIL_RESET;
    end
    else
    begin
      a_clk_sync  <= next_a_clk_sync;
      b_clk_sync  <= next_b_clk_sync;
      a_clk_level <= next_a_clk_level;
      b_clk_level <= next_b_clk_level;
      a_ctl_s1    <= next_a_ctl_s1;
      a_ctl_s2    <= next_a_ctl_s2;
      a_ctl_s3    <= next_a_ctl_s3;
      b_ctl_s1    <= next_b_ctl_s1;
      b_ctl_s2    <= next_b_ctl_s2;
      b_ctl_s3    <= next_b_ctl_s3;
      a_data_s1   <= next_a_data_s1;
      a_data_s2   <= next_a_data_s2;
      a_data_s3   <= next_a_data_s3;
      b_data_s1   <= next_b_data_s1;
      b_data_s2   <= next_b_data_s2;
      b_data_s3   <= next_b_data_s3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  // ctl = {mailbox select, enable, write_not_read, chip_select_n}
  function automatic dpmb_pkg::dpmb_access_t dpmb_decode(input logic edge_seen, input logic [3:0] ctl);
    dpmb_pkg::dpmb_access_t kind;
    kind = dpmb_pkg::dpmb_idle;
    if (edge_seen && !ctl[0] && ctl[2])
    begin
      if (!ctl[3])
        kind = dpmb_pkg::dpmb_fifo_xfer;
      else if (ctl[1])
        kind = dpmb_pkg::dpmb_mail_wr;
      else
        kind = dpmb_pkg::dpmb_mail_rd;
    end
    return kind;
  endfunction

  logic                   a_edge;
  logic                   b_edge;
  dpmb_pkg::dpmb_access_t a_access;
  dpmb_pkg::dpmb_access_t b_access;

  // rise counts once both late stages agree high and the held level was low
  assign a_edge   = a_clk_sync[1] & a_clk_sync[2] & ~a_clk_level;
  assign b_edge   = b_clk_sync[1] & b_clk_sync[2] & ~b_clk_level;
  assign a_access = dpmb_decode(a_edge, a_ctl_s3);
  assign b_access = dpmb_decode(b_edge, b_ctl_s3);

  ////////////////////////////////////////////////////////////////////////////
  // mailbox core

  logic [35:0] mail_a_to_b;
  logic [35:0] mail_b_to_a;
  logic [35:0] next_mail_a_to_b;
  logic [35:0] next_mail_b_to_a;
  logic        next_mail_a_to_b_flag_n;
  logic        next_mail_b_to_a_flag_n;
  logic [35:0] next_port_a_data_out;
  logic [35:0] next_port_b_data_out;
  logic        next_port_a_data_oe_n;
  logic        next_port_b_data_oe_n;
  logic        next_fifo_write;
  logic [35:0] next_fifo_write_data;
  logic        next_fifo_read;

  always_comb
  begin
    next_mail_a_to_b        = mail_a_to_b;
    next_mail_b_to_a        = mail_b_to_a;
    next_mail_a_to_b_flag_n = mail_a_to_b_flag_n;
    next_mail_b_to_a_flag_n = mail_b_to_a_flag_n;
    next_fifo_write         = 1'b0;
    next_fifo_write_data    = fifo_write_data;
    next_fifo_read          = 1'b0;

    // reads first so a same-cycle write into an empty box still leaves it full; a write to a full box is dropped
    if (b_access == dpmb_pkg::dpmb_mail_rd)
      next_mail_a_to_b_flag_n = dpmb_pkg::FLAG_EMPTY;
    if (a_access == dpmb_pkg::dpmb_mail_rd)
      next_mail_b_to_a_flag_n = dpmb_pkg::FLAG_EMPTY;

    case (a_access)
      dpmb_pkg::dpmb_mail_wr:
      begin
        if (mail_a_to_b_flag_n == dpmb_pkg::FLAG_EMPTY)
        begin
          next_mail_a_to_b        = a_data_s3;
          next_mail_a_to_b_flag_n = dpmb_pkg::FLAG_FULL;
        end
      end
      dpmb_pkg::dpmb_fifo_xfer:
      begin
        // port A only feeds the queue; its reads of the queue do not exist
        if (a_ctl_s3[1])
        begin
          next_fifo_write      = 1'b1;
          next_fifo_write_data = a_data_s3;
        end
      end
      default:
      begin
      end
    endcase

    case (b_access)
      dpmb_pkg::dpmb_mail_wr:
      begin
        if (mail_b_to_a_flag_n == dpmb_pkg::FLAG_EMPTY)
        begin
          next_mail_b_to_a        = b_data_s3;
          next_mail_b_to_a_flag_n = dpmb_pkg::FLAG_FULL;
        end
      end
      dpmb_pkg::dpmb_fifo_xfer:
      begin
        if (!b_ctl_s3[1])
          next_fifo_read = 1'b1;
      end
      default:
      begin
      end
    endcase

    // outputs are live while the port is selected for reading
    next_port_a_data_oe_n = (!a_ctl_s3[0] && !a_ctl_s3[1]) ? dpmb_pkg::OE_ON : dpmb_pkg::OE_OFF;
    next_port_b_data_oe_n = (!b_ctl_s3[0] && !b_ctl_s3[1]) ? dpmb_pkg::OE_ON : dpmb_pkg::OE_OFF;
    next_port_a_data_out  = next_mail_b_to_a;
    if (b_ctl_s3[3])
      next_port_b_data_out = next_mail_a_to_b;
    else
      next_port_b_data_out = fifo_out_data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mail_a_to_b        <= dpmb_pkg::MAIL_RESET;
      mail_b_to_a        <= dpmb_pkg::MAIL_RESET;
      mail_a_to_b_flag_n <= dpmb_pkg::FLAG_EMPTY;
      mail_b_to_a_flag_n <= dpmb_pkg::FLAG_EMPTY;
      port_a_data_out    <= dpmb_pkg::MAIL_RESET;
      port_b_data_out    <= dpmb_pkg::MAIL_RESET;
      port_a_data_oe_n   <= dpmb_pkg::OE_OFF;
      port_b_data_oe_n   <= dpmb_pkg::OE_OFF;
      fifo_write         <= 1'b0;
      fifo_write_data    <= dpmb_pkg::MAIL_RESET;
      fifo_read          <= 1'b0;
    end
    else
    begin
      mail_a_to_b        <= next_mail_a_to_b;
      mail_b_to_a        <= next_mail_b_to_a;
      mail_a_to_b_flag_n <= next_mail_a_to_b_flag_n;
      mail_b_to_a_flag_n <= next_mail_b_to_a_flag_n;
      port_a_data_out    <= next_port_a_data_out;
      port_b_data_out    <= next_port_b_data_out;
      port_a_data_oe_n   <= next_port_a_data_oe_n;
      port_b_data_oe_n   <= next_port_b_data_oe_n;
      fifo_write         <= next_fifo_write;
      fifo_write_data    <= next_fifo_write_data;
      fifo_read          <= next_fifo_read;
    end
  end

endmodule

// ### testbench/dpmb_properties.sv
module dpmb_properties (
  // clock, reset and port pins
  input wire logic        mclk, rst_n,
  input wire logic        port_a_clock, port_a_write_not_read, mailbox_select_a,
  input wire logic        port_b_clock, port_b_write_not_read, mailbox_select_b,
  // watched outputs and the FIFO read word
  input wire logic        mail_a_to_b_flag_n, mail_b_to_a_flag_n,
  input wire logic [35:0] port_a_data_out, port_b_data_out, fifo_out_data
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////
  // pins hold at least 6 cycles past the port clock rise, so a lag of 2 tolerates one cycle of skew
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  chk_ab_load: assert property (
    $fell(mail_a_to_b_flag_n) |-> $past(port_a_clock, 2) && mailbox_select_a && port_a_write_not_read)
    else $error("a-to-b flag set without mail write");
  chk_ba_load: assert property (
    $fell(mail_b_to_a_flag_n) |-> $past(port_b_clock, 2) && mailbox_select_b && port_b_write_not_read)
    else $error("b-to-a flag set without mail write");
  chk_ab_clear: assert property (
    $rose(mail_a_to_b_flag_n) |-> $past(port_b_clock, 2) && mailbox_select_b && !port_b_write_not_read)
    else $error("a-to-b flag cleared without mail read");
  chk_ba_clear: assert property (
    $rose(mail_b_to_a_flag_n) |-> $past(port_a_clock, 2) && mailbox_select_a && !port_a_write_not_read)
    else $error("b-to-a flag cleared without mail read");
  chk_ba_hold: assert property (
    $past(!mail_b_to_a_flag_n) |-> $stable(port_a_data_out))
    else $error("full b-to-a box changed");
  chk_a_out_cause: assert property (
    $changed(port_a_data_out) |-> $fell(mail_b_to_a_flag_n))
    else $error("port A data moved without a mail load");
  chk_b_fifo_path: assert property (
    !mailbox_select_b[*4] |=> port_b_data_out == $past(fifo_out_data))
    else $error("port B not showing fifo word");
  chk_b_mail_hold: assert property (
    mailbox_select_b[*5] ##1 mailbox_select_b && $past(!mail_a_to_b_flag_n) && !mail_a_to_b_flag_n
    |-> $stable(port_b_data_out))
    else $error("port B mail view moved");
  cover property ($fell(mail_a_to_b_flag_n));
  cover property ($rose(mail_b_to_a_flag_n));
  cover property (!mailbox_select_b[*5]);
endmodule

// ### testbench/dpmb_port_model.sv
module dpmb_port_model (
  // pins toward one mailbox port
  input  wire logic        clk,
  output logic             pclk,
  output logic             cs_n,
  output logic             wnr,
  output logic             en,
  output logic             mb,
  output logic      [35:0] d
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {pclk, cs_n, wnr, en, mb} = 5'h08;
    d = 36'h0;
  end
  // pins settle h cycles before the port clock rise and hold h cycles past its fall
  task automatic access(input logic w, input logic m, input logic [35:0] v, input int h);
    @(posedge clk);
    {cs_n, en, wnr, mb, d} <= {2'b01, w, m, v};
    repeat (h) @(posedge clk);
    pclk <= 1'b1;
    repeat (h) @(posedge clk);
    pclk <= 1'b0;
    repeat (h) @(posedge clk);
    // released bus never keeps a stale copy
    {cs_n, en, d} <= {2'b10, ~v};
  endtask
endmodule

// ### testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, rst_n, fifo_write, fifo_read, mail_a_to_b_flag_n, mail_b_to_a_flag_n;
  logic        port_a_clock, port_a_chip_select_n, port_a_write_not_read, port_a_enable, mailbox_select_a;
  logic        port_b_clock, port_b_chip_select_n, port_b_write_not_read, port_b_enable, mailbox_select_b;
  logic        port_a_data_oe_n, port_b_data_oe_n;
  logic [35:0] port_a_data_in, port_b_data_in, port_a_data_out, port_b_data_out, fifo_out_data, fifo_write_data;
  logic [35:0] va, vb, vf;
  int          seed, miscompares, tests_run;
  int          n_fw, n_fr;

  dpmb_mailbox dut_u (.*);
  dpmb_port_model pa_u (.clk(mclk), .pclk(port_a_clock), .cs_n(port_a_chip_select_n),
    .wnr(port_a_write_not_read), .en(port_a_enable), .mb(mailbox_select_a), .d(port_a_data_in));
  dpmb_port_model pb_u (.clk(mclk), .pclk(port_b_clock), .cs_n(port_b_chip_select_n),
    .wnr(port_b_write_not_read), .en(port_b_enable), .mb(mailbox_select_b), .d(port_b_data_in));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // queue pulses last one cycle, so they are tallied as they stand
  always @(posedge mclk)
  begin
    if (fifo_write === 1'b1)
      n_fw++;
    if (fifo_read === 1'b1)
      n_fr++;
  end

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // set-up of 3 or 4 cycles: prompt and slow partners alike
  task automatic xfer(input logic b, input logic w, input logic m, input logic [35:0] v);
    int h;
    h = 3 + ($random(seed) & 1);
    if (b)
      pb_u.access(w, m, v, h);
    else
      pa_u.access(w, m, v, h);
    @(negedge mclk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    seed = 22154;
    miscompares = 0;
    tests_run = 0;
    rst_n = 1'b0;
    fifo_out_data = 36'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      va = (i == 0) ? 36'hFFFFFFFFF : 36'({$random(seed), $random(seed)});
      vb = (i == 0) ? 36'h800000001 : 36'({$random(seed), $random(seed)});
      vf = 36'({$random(seed), $random(seed)});
      xfer(1'b0, 1'b1, 1'b1, va);
      xfer(1'b1, 1'b1, 1'b1, vb);
      check("flag_ab", mail_a_to_b_flag_n, 1'b0);
      check("flag_ba", mail_b_to_a_flag_n, 1'b0);
      check("b_mail", port_b_data_out, va);
      check("a_mail", port_a_data_out, vb);
      xfer(1'b0, 1'b1, 1'b1, ~va);
      xfer(1'b1, 1'b1, 1'b1, ~vb);
      xfer(1'b1, 1'b0, 1'b1, vf);
      check("oe_b_rd", port_b_data_oe_n, 1'b0);
      xfer(1'b0, 1'b0, 1'b1, vf);
      check("oe_a_rd", port_a_data_oe_n, 1'b0);
      check("flag_ab_rd", mail_a_to_b_flag_n, 1'b1);
      check("flag_ba_rd", mail_b_to_a_flag_n, 1'b1);
      check("b_keep", port_b_data_out, va);
      check("a_keep", port_a_data_out, vb);
      xfer(1'b0, 1'b1, 1'b0, vf);
      check("fifo_data", fifo_write_data, vf);
      check("flag_ab_fifo", mail_a_to_b_flag_n, 1'b1);
      fifo_out_data <= ~vf;
      xfer(1'b1, 1'b0, 1'b0, vf);
      check("b_fifo", port_b_data_out, ~vf);
      check("fifo_wr_cnt", 36'(n_fw), 36'(i + 1));
      check("fifo_rd_cnt", 36'(n_fr), 36'(i + 1));
    end
    close_out();
  end

  // cuts a hang short
  initial
  begin
    #500us;
    miscompares++;
    close_out();
  end
endmodule

bind dpmb_mailbox dpmb_properties chk_u (.*);
